// ==== rtl/power_mode_clock_select.sv ====
// Power mode controller with glitch-free clock source selection
module power_mode_clock_select
    import pm_clock_pkg::*;
#(
    parameter int SWITCH_COUNT = SWITCH_TICKS
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    // Software control
    input wire logic CTRL_WR_I,
    input wire osc_ctrl_s CTRL_WDATA_I,
    input wire logic SECONDARY_OSC_ENABLE_I,
    input wire logic TWO_SPEED_I,
    input wire logic PRI_IS_INTERNAL_I,
    // CPU events
    input wire logic SLEEP_I,
    input wire logic IRQ_I,
    input wire logic WDT_TIMEOUT_I,
    // Oscillator sources
    input wire logic PRI_READY_I,
    input wire logic INT_STABLE_I,
    input wire src_tick_s SRC_TICK_I,
    // Control readback and status
    output osc_ctrl_s CTRL_O,
    output clk_status_s STATUS_O,
    output pm_state_e MODE_O,
    // Clock gating, oscillator control and watchdog reset
    output clk_src_e CLK_SRC_O,
    output logic CPU_CLK_EN_O,
    output logic PERIPH_CLK_EN_O,
    output logic PRI_OSC_EN_O,
    output logic WDT_RESET_O
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        pm_state_e st;
        clk_src_e src;
        clk_src_e tgt_src;
        logic tgt_idle;
        logic ret;
        logic [CNT_W-1:0] cnt;
        osc_ctrl_s ctrl;
        clk_status_s flags;
        logic cpu_en;
        logic per_en;
        logic pri_en;
        logic wdt_rst;
    } pm_s;

    pm_s q_r;
    pm_s q_nxt;
    clk_src_e sel_src;
    logic tgt_tick;
    logic running;

    // Decode of the select field; the low bit means nothing once bit 1 is set
    always_comb begin
        if (q_r.ctrl.clock_source_select[1]) begin
            sel_src = SRC_INT;
        end else if (q_r.ctrl.clock_source_select == SEL_SECONDARY) begin
            sel_src = SRC_SEC;
        end else begin
            sel_src = SRC_PRI;
        end
    end

    // Tick of the source being switched to
    always_comb begin
        case (q_r.tgt_src)
            SRC_PRI: tgt_tick = SRC_TICK_I.pri;
            SRC_SEC: tgt_tick = SRC_TICK_I.sec;
            default: tgt_tick = SRC_TICK_I.intl;
        endcase
    end

    // Next state of the whole controller
    always_comb begin
        q_nxt = q_r;
        q_nxt.wdt_rst = 1'b0;
        running = 1'b0;
        // Software writes only touch the idle enable and select bits, never the active mode
        if (CTRL_WR_I) begin
            q_nxt.ctrl.idle_enable = CTRL_WDATA_I.idle_enable;
            q_nxt.ctrl.clock_source_select[1] = CTRL_WDATA_I.clock_source_select[1];
            if (SECONDARY_OSC_ENABLE_I || !CTRL_WDATA_I.clock_source_select[0]) begin
                q_nxt.ctrl.clock_source_select[0] = CTRL_WDATA_I.clock_source_select[0];
            end
        end
        case (q_r.st)
            ST_RUN: begin
                if (WDT_TIMEOUT_I) begin
                    q_nxt.wdt_rst = 1'b1;
                end else if (SLEEP_I) begin
                    if (!q_r.ctrl.idle_enable && q_r.ctrl.clock_source_select == SEL_PRIMARY) begin
                        q_nxt.st = ST_SLEEP;
                        q_nxt.ret = 1'b0;
                    end else if (sel_src != q_r.src) begin
                        q_nxt.st = ST_SWITCH;
                        q_nxt.tgt_src = sel_src;
                        q_nxt.tgt_idle = q_r.ctrl.idle_enable;
                        q_nxt.cnt = '0;
                        q_nxt.ret = 1'b0;
                    end else if (q_r.ctrl.idle_enable) begin
                        q_nxt.st = ST_IDLE;
                        q_nxt.ret = 1'b0;
                    end
                end else if (q_r.src != SRC_PRI && (q_r.ret || IRQ_I) && PRI_READY_I) begin
                    // Primary became ready after a wake: return to it automatically
                    q_nxt.st = ST_SWITCH;
                    q_nxt.tgt_src = SRC_PRI;
                    q_nxt.tgt_idle = 1'b0;
                    q_nxt.cnt = '0;
                    q_nxt.ret = 1'b0;
                end else if (q_r.src != SRC_PRI && IRQ_I) begin
                    q_nxt.ret = 1'b1;
                end
            end
            ST_SWITCH: begin
                // Clocks stay off while whole periods of the new source are counted
                if (tgt_tick) begin
                    q_nxt.cnt = q_r.cnt + 1'b1;
                end
                if (tgt_tick && q_r.cnt == CNT_W'(SWITCH_COUNT - 1)) begin
                    q_nxt.src = q_r.tgt_src;
                    q_nxt.st = q_r.tgt_idle ? ST_IDLE : ST_RUN;
                end
            end
            ST_IDLE: begin
                // Only an interrupt or watchdog time-out ends an idle mode
                if (IRQ_I || WDT_TIMEOUT_I) begin
                    q_nxt.st = ST_HOLD;
                    q_nxt.cnt = '0;
                end
            end
            ST_HOLD: begin
                // Peripherals keep running while the CPU gets ready
                q_nxt.cnt = q_r.cnt + 1'b1;
                if (q_r.cnt == CNT_W'(WAKE_HOLD_CYC - 1)) begin
                    q_nxt.st = ST_RUN;
                    q_nxt.ret = (q_r.src != SRC_PRI);
                end
            end
            ST_SLEEP: begin
                if (IRQ_I || WDT_TIMEOUT_I) begin
                    q_nxt.st = ST_SLWAKE;
                    q_nxt.src = TWO_SPEED_I ? SRC_INT : SRC_PRI;
                end
            end
            ST_SLWAKE: begin
                // Either unclocked or on the internal block until primary is up
                if (PRI_READY_I) begin
                    if (q_r.src == SRC_PRI) begin
                        q_nxt.st = ST_RUN;
                    end else begin
                        q_nxt.st = ST_SWITCH;
                        q_nxt.tgt_src = SRC_PRI;
                        q_nxt.tgt_idle = 1'b0;
                        q_nxt.cnt = '0;
                    end
                end
            end
            default: begin
                q_nxt.st = ST_SLWAKE;
            end
        endcase
        // Gates and oscillator enable follow the next state
        case (q_nxt.st)
            ST_RUN: begin
                q_nxt.cpu_en = 1'b1;
                q_nxt.per_en = 1'b1;
                running = 1'b1;
            end
            ST_IDLE, ST_HOLD: begin
                q_nxt.cpu_en = 1'b0;
                q_nxt.per_en = 1'b1;
                running = 1'b1;
            end
            ST_SLWAKE: begin
                q_nxt.cpu_en = TWO_SPEED_I && q_nxt.src == SRC_INT;
                q_nxt.per_en = q_nxt.cpu_en;
                running = q_nxt.cpu_en;
            end
            default: begin
                q_nxt.cpu_en = 1'b0;
                q_nxt.per_en = 1'b0;
            end
        endcase
        // Primary runs outside sleep when it is the source or is being brought back
        q_nxt.pri_en = (q_nxt.st != ST_SLEEP) && (q_nxt.src == SRC_PRI || q_nxt.ret
            || q_nxt.st == ST_SLWAKE
            || (q_nxt.st == ST_SWITCH && q_nxt.tgt_src == SRC_PRI));
        // Flags are held through a switch so software never sees a half state
        if (q_nxt.st != ST_SWITCH) begin
            q_nxt.flags.primary_active_flag = running && q_nxt.src == SRC_PRI;
            q_nxt.flags.secondary_active_flag = running && q_nxt.src == SRC_SEC;
            q_nxt.flags.internal_stable_flag = running && INT_STABLE_I
                && (q_nxt.src == SRC_INT || (q_nxt.src == SRC_PRI && PRI_IS_INTERNAL_I));
        end
    end

    // One register for all controller state
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            q_r <= '{st: ST_SLWAKE, src: SRC_PRI, tgt_src: SRC_PRI, tgt_idle: 1'b0,
                ret: 1'b0, cnt: '0,
                ctrl: '{idle_enable: RST_IDLE_ENABLE,
                    clock_source_select: RST_SOURCE_SELECT},
                flags: '0, cpu_en: 1'b0, per_en: 1'b0, pri_en: 1'b1, wdt_rst: 1'b0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs straight from the state register
    assign CTRL_O = q_r.ctrl;
    assign STATUS_O = q_r.flags;
    assign MODE_O = q_r.st;
    assign CLK_SRC_O = q_r.src;
    assign CPU_CLK_EN_O = q_r.cpu_en;
    assign PERIPH_CLK_EN_O = q_r.per_en;
    assign PRI_OSC_EN_O = q_r.pri_en;
    assign WDT_RESET_O = q_r.wdt_rst;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);

    sequence sleep_in_run;
        q_r.st == ST_RUN && SLEEP_I && !WDT_TIMEOUT_I;
    endsequence

    sequence switch_done;
        q_r.st == ST_SWITCH && tgt_tick && q_r.cnt == CNT_W'(SWITCH_COUNT - 1);
    endsequence

    chk_sleep_entry: assert property (sleep_in_run ##0 (q_r.ctrl == 3'h0)
        |=> q_r.st == ST_SLEEP && !CPU_CLK_EN_O && !PERIPH_CLK_EN_O)
        else $error("sleep entry wrong");
    chk_source_decode: assert property (sleep_in_run ##0 q_r.ctrl.clock_source_select[1]
        ##0 (q_r.src != SRC_INT) |=> q_r.st == ST_SWITCH && q_r.tgt_src == SRC_INT)
        else $error("internal select not decoded");
    chk_idle_gating: assert property (q_r.st == ST_IDLE |-> !CPU_CLK_EN_O && PERIPH_CLK_EN_O)
        else $error("idle gating wrong");
    chk_no_early_switch: assert property (q_r.st == ST_RUN && !SLEEP_I && !q_r.ret && !IRQ_I
        |=> q_r.st != ST_SWITCH && $stable(q_r.src))
        else $error("clock changed without sleep");
    chk_switch_pause: assert property (switch_done |=> q_r.st != ST_SWITCH
        && q_r.src == $past(q_r.tgt_src))
        else $error("switch did not end after count");
    chk_switch_gated: assert property (q_r.st == ST_SWITCH |-> !CPU_CLK_EN_O && !PERIPH_CLK_EN_O)
        else $error("clocks ran during switch");
    chk_one_flag: assert property (q_r.src != SRC_PRI |-> $onehot0(STATUS_O))
        else $error("several source flags set");
    chk_sleep_flag: assert property (q_r.st == ST_SLEEP
        |-> !STATUS_O.primary_active_flag && !PRI_OSC_EN_O)
        else $error("primary alive in sleep");
    chk_wdt_run: assert property (q_r.st == ST_RUN && WDT_TIMEOUT_I |=> WDT_RESET_O)
        else $error("watchdog reset missing in run");
    chk_idle_stays: assert property (q_r.st == ST_IDLE && !IRQ_I && !WDT_TIMEOUT_I
        |=> q_r.st == ST_IDLE)
        else $error("idle left without event");
    chk_hold_length: assert property (q_r.st == ST_RUN && $past(q_r.st) == ST_HOLD
        |-> $past(q_r.cnt) == CNT_W'(WAKE_HOLD_CYC - 1))
        else $error("wake hold length wrong");
    chk_auto_return: assert property (q_r.st == ST_RUN && q_r.ret && PRI_READY_I
        && !SLEEP_I && !WDT_TIMEOUT_I && q_r.src != SRC_PRI
        |=> q_r.st == ST_SWITCH && q_r.tgt_src == SRC_PRI)
        else $error("no return to primary");
    chk_bits_kept: assert property (!CTRL_WR_I |=> $stable(CTRL_O))
        else $error("control bits changed without write");
    chk_low_bit_lock: assert property (CTRL_WR_I && !SECONDARY_OSC_ENABLE_I
        && !CTRL_O.clock_source_select[0] |=> !CTRL_O.clock_source_select[0])
        else $error("low select bit set while secondary off");

endmodule

// ==== rtl/pm_clock_pkg.sv ====
// Package with types and constants for the power mode clock selector
package pm_clock_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;          // 250 MHz system clock
    localparam int WAKE_HOLD_NS = 10000;       // CPU hold-off after an idle wake
    localparam int WAKE_HOLD_CYC = (WAKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SWITCH_TICKS = 8;           // New-source periods counted per switch
    localparam int CNT_W = 12;

    // ****************************************
    // Control field layout and reset values
    // ****************************************
    localparam logic RST_IDLE_ENABLE = 1'h0;
    localparam logic [1:0] RST_SOURCE_SELECT = 2'h0;
    localparam logic [1:0] SEL_PRIMARY = 2'h0;
    localparam logic [1:0] SEL_SECONDARY = 2'h1;

    // ****************************************
    // Enumerations
    // ****************************************
    typedef enum logic [5:0] {
        ST_RUN    = 6'h01,
        ST_SWITCH = 6'h02,
        ST_IDLE   = 6'h04,
        ST_HOLD   = 6'h08,
        ST_SLEEP  = 6'h10,
        ST_SLWAKE = 6'h20
    } pm_state_e;

    typedef enum logic [1:0] {
        SRC_PRI = 2'h0,
        SRC_SEC = 2'h1,
        SRC_INT = 2'h2
    } clk_src_e;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic idle_enable;
        logic [1:0] clock_source_select;
    } osc_ctrl_s;

    typedef struct packed {
        logic primary_active_flag;
        logic internal_stable_flag;
        logic secondary_active_flag;
    } clk_status_s;

    typedef struct packed {
        logic pri;
        logic sec;
        logic intl;
    } src_tick_s;

endpackage

// ==== tb/osc_source_model.sv ====
// Model of the oscillator sources feeding the power mode controller
module osc_source_model
    import pm_clock_pkg::*;
(
    // Clock and primary enable
    input wire logic clk_i,
    input wire logic pri_osc_en_i,
    // Source outputs
    output src_tick_s tick_o,
    output logic pri_ready_o,
    output logic int_stable_o
);
    timeunit 1ns;
    timeprecision 100ps;

    int n = 0;
    int warm = 0;

    initial begin
        tick_o = '0;
        pri_ready_o = 1'b0;
        int_stable_o = 1'b0;
    end

    // Unrelated tick rates; primary ready only after warm-up, lost at once when disabled
    always @(posedge clk_i) begin
        #1;
        n++;
        tick_o <= {n % 3 == 0, n % 7 == 0, n % 2 == 0};
        warm = pri_osc_en_i ? warm + 1 : 0;
        pri_ready_o <= warm > 30;
        int_stable_o <= n > 40;
    end
endmodule

// ==== tb/power_mode_clock_select_tb_top.sv ====
// Self-checking bench for the power mode clock selector
module power_mode_clock_select_tb_top import pm_clock_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Signals and instances
    // ****************************************
    localparam int SW_N = 8;
    logic clk = 0, rst_n = 0, wr = 0, sec_en = 1, two_spd = 0, sleep = 0, irq = 0, wdt = 0;
    logic pri_int = 0;
    osc_ctrl_s wdata = '0;
    osc_ctrl_s ctrl;
    logic pri_rdy, int_stb, cpu_en, per_en, pri_en, wdt_rst;
    src_tick_s tick;
    clk_status_s stat;
    pm_state_e mode;
    clk_src_e src;
    clk_src_e tgt = SRC_PRI;
    int err_total = 0, compares = 0, cyc = 0, sw_ticks = 0, hold_n = 0, wdt_n = 0;

    power_mode_clock_select #(.SWITCH_COUNT(SW_N)) i_dut (
        .CLOCK_I(clk), .RSTN_I(rst_n), .CTRL_WR_I(wr), .CTRL_WDATA_I(wdata),
        .SECONDARY_OSC_ENABLE_I(sec_en), .TWO_SPEED_I(two_spd), .PRI_IS_INTERNAL_I(pri_int),
        .SLEEP_I(sleep), .IRQ_I(irq), .WDT_TIMEOUT_I(wdt), .PRI_READY_I(pri_rdy),
        .INT_STABLE_I(int_stb), .SRC_TICK_I(tick), .CTRL_O(ctrl), .STATUS_O(stat),
        .MODE_O(mode), .CLK_SRC_O(src), .CPU_CLK_EN_O(cpu_en), .PERIPH_CLK_EN_O(per_en),
        .PRI_OSC_EN_O(pri_en), .WDT_RESET_O(wdt_rst));

    osc_source_model i_osc (.clk_i(clk), .pri_osc_en_i(pri_en), .tick_o(tick),
        .pri_ready_o(pri_rdy), .int_stable_o(int_stb));

    initial begin
        forever #2 clk = ~clk;
    end

    // ****************************************
    // Helpers and expectations
    // ****************************************
    function automatic logic tick_of(input clk_src_e s);
        return s == SRC_PRI ? tick.pri : s == SRC_SEC ? tick.sec : tick.intl;
    endfunction

    // Low select bit is ignored once the high bit picks the internal block
    function automatic clk_src_e src_of(input logic [1:0] sel);
        return sel[1] ? SRC_INT : clk_src_e'(sel);
    endfunction

    function automatic logic [2:0] flags_of(input clk_src_e s);
        // Internal block as primary shows both flags while on the primary source
        return s == SRC_PRI ? (pri_int ? 3'h6 : 3'h4) : s == SRC_SEC ? 3'h1 : 3'h2;
    endfunction

    // Counts pause ticks, hold cycles and watchdog reset pulses; also cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            give_verdict();
        end
        sw_ticks += (mode === ST_SWITCH && tick_of(tgt) === 1'b1);
        hold_n += (mode === ST_HOLD);
        wdt_n += (wdt_rst === 1'b1);
    end

    task automatic give_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Inputs move 1 ns after the edge so the design never races the bench
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        step(1);
        sig = 1'b0;
    endtask

    task automatic wait_for(input pm_state_e m, input clk_src_e s);
        int k;
        k = 0;
        while (!(mode === m && src === s) && k < 5000) begin
            step(1);
            k++;
        end
        cmp("wait state", 1, k < 5000);
    endtask

    task automatic write_ctrl(input osc_ctrl_s d);
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sleep_trip(input logic ts);
        two_spd = ts;
        write_ctrl('0);
        pulse(sleep);
        cmp("sleep mode", ST_SLEEP, mode);
        cmp("sleep clocks", 0, {cpu_en, per_en, pri_en});
        cmp("sleep flags", 0, stat);
        step(5);
        if (ts) pulse(wdt);
        else pulse(irq);
        cmp("wake mode", ST_SLWAKE, mode);
        cmp("wake clocks", ts ? 3'h7 : 3'h1, {cpu_en, per_en, pri_en});
        if (ts) cmp("wake src", SRC_INT, src);
        wait_for(ST_RUN, SRC_PRI);
        cmp("wake flags", 3'h4, stat);
        cmp("wake ctrl", 0, ctrl);
    endtask

    task automatic pm_trip(input osc_ctrl_s c);
        clk_src_e t;
        t = src_of(c.clock_source_select);
        tgt = t;
        write_ctrl(c);
        cmp("ctrl write", c, ctrl);
        cmp("src held", SRC_PRI, src);
        sw_ticks = 0;
        hold_n = 0;
        wdt_n = 0;
        pulse(sleep);
        if (t != SRC_PRI) begin
            cmp("switch mode", ST_SWITCH, mode);
            wait_for(c.idle_enable ? ST_IDLE : ST_RUN, t);
            cmp("pause ticks", SW_N, sw_ticks);
        end
        cmp("pm mode", c.idle_enable ? ST_IDLE : ST_RUN, mode);
        cmp("cpu clk", !c.idle_enable, cpu_en);
        cmp("periph clk", 1, per_en);
        cmp("pm flags", flags_of(t), stat);
        sw_ticks = 0;
        tgt = SRC_PRI;
        if (c.idle_enable) begin
            pulse(sleep);
            cmp("idle kept", ST_IDLE, mode);
            pulse(wdt);
            cmp("hold mode", ST_HOLD, mode);
            cmp("hold cpu", 0, cpu_en);
            wait_for(ST_RUN, t);
            cmp("hold length", WAKE_HOLD_CYC, hold_n);
            cmp("no wdt reset", 0, wdt_n);
        end else begin
            pulse(wdt);
            step(2);
            cmp("wdt reset", 1, wdt_n);
            cmp("run kept", ST_RUN, mode);
            pulse(irq);
        end
        wait_for(ST_RUN, SRC_PRI);
        if (t != SRC_PRI) cmp("return ticks", SW_N, sw_ticks);
        cmp("return flags", flags_of(SRC_PRI), stat);
        cmp("ctrl kept", c, ctrl);
        cmp("cpu back", 1, cpu_en);
    endtask

    // Every non-sleep mode once from a table, then random picks
    initial begin
        osc_ctrl_s c;
        void'($urandom(34859));
        step(5);
        cmp("reset ctrl", 0, ctrl);
        cmp("reset mode", ST_SLWAKE, mode);
        rst_n = 1'b1;
        wait_for(ST_RUN, SRC_PRI);
        cmp("boot flags", 3'h4, stat);
        sleep_trip(1'b0);
        sleep_trip(1'b1);
        sec_en = 1'b0;
        write_ctrl(3'h3);
        cmp("low bit refused", 3'h2, ctrl);
        step(1);
        write_ctrl(3'h7);
        cmp("low bit refused", 3'h6, ctrl);
        sec_en = 1'b1;
        for (int i = 1; i < 12; i++) begin
            pri_int = i[0];
            c = osc_ctrl_s'(3'(i));
            if (i > 7) c = osc_ctrl_s'(3'($urandom()));
            if (c == 3'h0) c = 3'h4;
            pm_trip(c);
        end
        give_verdict();
    end
endmodule
